/* common/dqd_pkg.sv */
// shared constants, types and decode helpers for the dual quadrature decoder
package dqd_pkg;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] STAT_IDX = 8'h90;
  localparam logic [7:0] CTRL_IDX = 8'h91;
  localparam logic [7:0] CNT1_IDX = 8'h94;
  localparam logic [7:0] CNT2_IDX = 8'h96;
  localparam int         IDX_LSB  = 2;

  // ==========================================================================
  // status and clear register bit positions
  localparam int STAT_C2_UP  = 7;
  localparam int STAT_C2_DN  = 6;
  localparam int STAT_C2_CLR = 4;
  localparam int STAT_C1_UP  = 3;
  localparam int STAT_C1_DN  = 2;
  localparam int STAT_C1_CLR = 0;

  // ==========================================================================
  // control register fields
  localparam int CTRL_C2_HI = 7;
  localparam int CTRL_C2_LO = 6;
  localparam int CTRL_C1_HI = 3;
  localparam int CTRL_C1_LO = 2;
  localparam int CTRL_PR_HI = 1;
  localparam int CTRL_PR_LO = 0;
  localparam int SEL_EN_BIT = 1;
  localparam int SEL_HI_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] FLAG_RESET = 4'h0;

  // ==========================================================================
  // port bit pairs, in-phase on the odd bit
  localparam int C1_LO_I = 1;
  localparam int C1_LO_Q = 0;
  localparam int C1_HI_I = 5;
  localparam int C1_HI_Q = 4;
  localparam int C2_LO_I = 3;
  localparam int C2_LO_Q = 2;
  localparam int C2_HI_I = 7;
  localparam int C2_HI_Q = 6;

  // filter needs this many equal tick samples
  localparam int FILTER_TICKS = 2;

  typedef struct packed {
    logic i;
    logic q;
  } dqd_phase_s;

  // in-phase leading: 00 -> 10 -> 11 -> 01 -> 00
  function automatic logic dqd_is_up(dqd_phase_s prev, dqd_phase_s cur);
    return (cur.i == ~prev.q) && (cur.q == prev.i);
  endfunction

  function automatic logic dqd_is_dn(dqd_phase_s prev, dqd_phase_s cur);
    return (cur.q == ~prev.i) && (cur.i == prev.q);
  endfunction

endpackage

/* src/dqd_filter.sv */
// glitch filter for one phase input, advanced on prescale ticks
`timescale 1ns/1ps
module dqd_filter (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic raw,
  output logic      filt
);
  logic samp_reg;
  logic filt_reg;
  wire  agree = tick & (raw == samp_reg) & (raw != filt_reg);

  always_ff @(posedge clock) begin
    if (rst) begin
      samp_reg <= 1'b0;
      filt_reg <= 1'b0;
    end else begin
      if (tick) begin
        samp_reg <= raw;
      end
      if (agree) begin
        filt_reg <= raw;
      end
    end
  end

  assign filt = filt_reg;

  // ==========================================================================
  // assertions
  one_tick_reject_a: assert property (@(posedge clock) disable iff (rst)
    (tick && raw != samp_reg) |=> $stable(filt_reg))
    else $error("filter followed a one-tick pulse");
endmodule

/* src/dqd_channel.sv */
// one decoder channel: input select, direction decode and position count
`timescale 1ns/1ps
module dqd_channel #(
  parameter int COUNT_W = 8
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               tick,
  input  wire logic [1:0]         sel,
  input  dqd_pkg::dqd_phase_s     lo_pair,
  input  dqd_pkg::dqd_phase_s     hi_pair,
  input  wire logic               clear,
  output logic [COUNT_W-1:0]      count,
  output logic                    up_wrap,
  output logic                    dn_wrap
);
  dqd_pkg::dqd_phase_s prev_reg;
  logic [1:0]          sel_reg;
  logic [COUNT_W-1:0]  count_reg;
  logic [COUNT_W-1:0]  count_next;

  wire dqd_pkg::dqd_phase_s cur = sel[dqd_pkg::SEL_HI_BIT] ? hi_pair : lo_pair;
  wire sel_same = (sel == sel_reg);
  wire live     = tick & sel[dqd_pkg::SEL_EN_BIT] & sel_same;
  wire step_up  = live & dqd_pkg::dqd_is_up(prev_reg, cur);
  wire step_dn  = live & dqd_pkg::dqd_is_dn(prev_reg, cur);

  assign up_wrap = step_up & ~clear & (count_reg == {COUNT_W{1'b1}});
  assign dn_wrap = step_dn & ~clear & (count_reg == {COUNT_W{1'b0}});
  assign count_next = clear   ? {COUNT_W{1'b0}} :
                      step_up ? count_reg + 1'b1 :
                      step_dn ? count_reg - 1'b1 : count_reg;
  assign count = count_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_reg  <= '0;
      sel_reg   <= 2'h0;
      count_reg <= '0;
    end else begin
      sel_reg   <= sel;
      if (tick || !sel_same) begin
        prev_reg <= cur;
      end
      count_reg <= count_next;
    end
  end
endmodule

/* src/dqd_top.sv */
// dual quadrature decoder with Avalon-MM register slave
// Contract
// - ch2 up-wrap sets status bit 7
// - ch2 down-wrap sets status bit 6
// - ch1 up-wrap sets status bit 3
// - ch1 down-wrap sets status bit 2
// - status read clears the wrap flags
// - status bits 5 and 1 read zero
// - writing bit 4 zeroes ch2, no flag
// - writing bit 0 zeroes ch1, no flag
// - writing zero leaves counters alone
// - ch2 select: 10 bits 3/2, 11 bits 7/6
// - ch2 disable; select change never steps
// - ch1 select: 10 bits 1/0, 11 bits 5/4
// - ch1 disable; select change never steps
// - control bits 5:4 are ignored
// - control 1:0 gives interrupt priority, 0 off
// - count registers read present counts
// - phase filter rejects sub-two-tick pulses
// - in-phase odd bit, quadrature even bit
// - decoder advances only on prescale ticks
// - interrupt rises with flag, read clears
`timescale 1ns/1ps
module dqd_top #(
  parameter int ADDR_W  = 10,
  parameter int COUNT_W = 8
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        prescale_tick,
  input  wire logic [7:0]  port_in,
  output logic             irq,
  output logic [1:0]       irq_priority
);

  // ==========================================================================
  // elaboration checks
  initial begin
    if (COUNT_W != 8) begin
      $error("count width must be 8 to fit the register");
    end
    if (ADDR_W < 10) begin
      $error("address too narrow for the register map");
    end
  end

  // ==========================================================================
  // state
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [3:0]  flags_reg;
  logic [3:0]  flags_next;
  logic [3:0]  seen_reg;
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;

  // ==========================================================================
  // input filters
  logic [7:0] filt;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_filt
      dqd_filter u_filt (
        .clock (clock),
        .rst   (rst),
        .tick  (prescale_tick),
        .raw   (port_in[g]),
        .filt  (filt[g])
      );
    end
  endgenerate

  // in-phase on the odd bit, quadrature on the even bit
  wire dqd_pkg::dqd_phase_s c1_lo = {filt[dqd_pkg::C1_LO_I], filt[dqd_pkg::C1_LO_Q]};
  wire dqd_pkg::dqd_phase_s c1_hi = {filt[dqd_pkg::C1_HI_I], filt[dqd_pkg::C1_HI_Q]};
  wire dqd_pkg::dqd_phase_s c2_lo = {filt[dqd_pkg::C2_LO_I], filt[dqd_pkg::C2_LO_Q]};
  wire dqd_pkg::dqd_phase_s c2_hi = {filt[dqd_pkg::C2_HI_I], filt[dqd_pkg::C2_HI_Q]};

  wire [1:0] c1_sel = ctrl_reg[dqd_pkg::CTRL_C1_HI:dqd_pkg::CTRL_C1_LO];
  wire [1:0] c2_sel = ctrl_reg[dqd_pkg::CTRL_C2_HI:dqd_pkg::CTRL_C2_LO];
  wire [1:0] prio   = ctrl_reg[dqd_pkg::CTRL_PR_HI:dqd_pkg::CTRL_PR_LO];

  // ==========================================================================
  // bus decode
  wire [7:0] idx      = address[dqd_pkg::IDX_LSB +: 8];
  wire       req      = read | write;
  wire       accept   = req & ack_reg;
  wire       capture  = read & ~ack_reg;
  wire       hit_stat = (idx == dqd_pkg::STAT_IDX);
  wire       hit_ctrl = (idx == dqd_pkg::CTRL_IDX);
  wire       hit_cnt1 = (idx == dqd_pkg::CNT1_IDX);
  wire       hit_cnt2 = (idx == dqd_pkg::CNT2_IDX);
  wire       wr_lane  = write & accept & byteenable[0];
  wire       wr_stat  = wr_lane & hit_stat;
  wire       wr_ctrl  = wr_lane & hit_ctrl;
  wire       rd_stat  = read & accept & hit_stat;
  wire       clr1     = wr_stat & writedata[dqd_pkg::STAT_C1_CLR];
  wire       clr2     = wr_stat & writedata[dqd_pkg::STAT_C2_CLR];

  // ==========================================================================
  // channels
  logic [COUNT_W-1:0] cnt1;
  logic [COUNT_W-1:0] cnt2;
  logic               c1_up;
  logic               c1_dn;
  logic               c2_up;
  logic               c2_dn;

  dqd_channel #(.COUNT_W(COUNT_W)) u_ch1 (
    .clock   (clock),
    .rst     (rst),
    .tick    (prescale_tick),
    .sel     (c1_sel),
    .lo_pair (c1_lo),
    .hi_pair (c1_hi),
    .clear   (clr1),
    .count   (cnt1),
    .up_wrap (c1_up),
    .dn_wrap (c1_dn)
  );

  dqd_channel #(.COUNT_W(COUNT_W)) u_ch2 (
    .clock   (clock),
    .rst     (rst),
    .tick    (prescale_tick),
    .sel     (c2_sel),
    .lo_pair (c2_lo),
    .hi_pair (c2_hi),
    .clear   (clr2),
    .count   (cnt2),
    .up_wrap (c2_up),
    .dn_wrap (c2_dn)
  );

  // ==========================================================================
  // sticky flags, order {c2 up, c2 dn, c1 up, c1 dn}
  wire [3:0] flag_set = {c2_up, c2_dn, c1_up, c1_dn};
  wire [3:0] flag_clr = rd_stat ? seen_reg : 4'h0;
  assign flags_next = (flags_reg & ~flag_clr) | flag_set;

  wire [7:0] stat_view = {flags_reg[3], flags_reg[2], 1'b0, 1'b0,
                          flags_reg[1], flags_reg[0], 1'b0, 1'b0};
  wire [7:0] ctrl_view = {c2_sel, 2'h0, c1_sel, prio};

  assign ctrl_next = wr_ctrl ? {writedata[7:6], 2'h0, writedata[3:0]} : ctrl_reg;

  assign readdata_next = hit_stat ? {24'h000000, stat_view} :
                         hit_ctrl ? {24'h000000, ctrl_view} :
                         hit_cnt1 ? {24'h000000, cnt1} :
                         hit_cnt2 ? {24'h000000, cnt2} : 32'h00000000;

  // ==========================================================================
  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg     <= dqd_pkg::CTRL_RESET;
      flags_reg    <= dqd_pkg::FLAG_RESET;
      seen_reg     <= 4'h0;
      ack_reg      <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg  <= ctrl_next;
      flags_reg <= flags_next;
      ack_reg   <= req & ~ack_reg;
      if (capture) begin
        readdata_reg <= readdata_next;
        seen_reg     <= flags_reg;
      end
    end
  end

  // ==========================================================================
  // outputs
  assign waitrequest  = req & ~ack_reg;
  assign readdata     = readdata_reg;
  assign irq          = (|flags_reg) & (prio != 2'h0);
  assign irq_priority = prio;

  // ==========================================================================
  // assertions
  sequence stat_read_s;
    read && accept && hit_stat;
  endsequence

  sequence stat_clear_s;
    wr_stat;
  endsequence

  c2_up_flag_a: assert property (@(posedge clock) disable iff (rst)
    c2_up |=> flags_reg[3] && stat_view[dqd_pkg::STAT_C2_UP])
    else $error("ch2 up wrap did not set its flag");

  c2_dn_flag_a: assert property (@(posedge clock) disable iff (rst)
    (c2_dn && cnt2 == 8'h00) |=> flags_reg[2] && cnt2 == 8'hff)
    else $error("ch2 down wrap did not set its flag");

  c1_up_flag_a: assert property (@(posedge clock) disable iff (rst)
    (c1_up && cnt1 == 8'hff) |=> flags_reg[1] && cnt1 == 8'h00)
    else $error("ch1 up wrap did not set its flag");

  c1_dn_flag_a: assert property (@(posedge clock) disable iff (rst)
    c1_dn |=> flags_reg[0] && stat_view[dqd_pkg::STAT_C1_DN])
    else $error("ch1 down wrap did not set its flag");

  read_clear_a: assert property (@(posedge clock) disable iff (rst)
    (stat_read_s and (seen_reg[3] && !c2_up)) |=> !flags_reg[3])
    else $error("status read left a seen flag set");

  zero_bits_a: assert property (@(posedge clock) disable iff (rst)
    stat_read_s |-> readdata[5] == 1'b0 && readdata[1] == 1'b0)
    else $error("status bits 5 or 1 read as one");

  c2_clear_a: assert property (@(posedge clock) disable iff (rst)
    (stat_clear_s and clr2) |=> cnt2 == 8'h00 && !$rose(flags_reg[3]) && !$rose(flags_reg[2]))
    else $error("ch2 clear failed or raised a flag");

  c1_clear_a: assert property (@(posedge clock) disable iff (rst)
    (stat_clear_s and clr1) |=> cnt1 == 8'h00 && !$rose(flags_reg[1]) && !$rose(flags_reg[0]))
    else $error("ch1 clear failed or raised a flag");

  sel_no_step_a: assert property (@(posedge clock) disable iff (rst)
    ($changed(c2_sel) && !clr2) |=> $stable(cnt2))
    else $error("ch2 stepped on a select change");

  ignored_bits_a: assert property (@(posedge clock) disable iff (rst)
    wr_ctrl |=> ctrl_reg[5:4] == 2'h0 ##1 ctrl_reg[3:2] == $past(writedata[3:2], 2))
    else $error("control write stored wrong bits");

  tick_gate_a: assert property (@(posedge clock) disable iff (rst)
    (!prescale_tick && !clr1) |=> $stable(cnt1))
    else $error("ch1 counted without a tick");

  irq_same_a: assert property (@(posedge clock) disable iff (rst)
    ((c1_up || c2_dn) && prio != 2'h0 && !wr_ctrl) |=> irq && irq_priority == $past(prio))
    else $error("interrupt missing with wrap flag");
endmodule

/* sim/dqd_encoder.sv */
// incremental encoder model driving four phase pairs onto the parallel port
`timescale 1ns/1ps
module dqd_encoder (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       step,
  input  wire logic       dn,
  input  wire logic [1:0] pair,
  input  wire logic [7:0] flip,
  output logic [7:0]      port_out
);
  // ==========================================================================
  // shaft position of each pair
  logic [1:0] pos_reg [4];
  always_ff @(posedge clock) begin
    if (rst) begin
      pos_reg <= '{default: 2'h0};
    end else if (step) begin
      pos_reg[pair] <= dn ? pos_reg[pair] - 2'h1 : pos_reg[pair] + 2'h1;
    end
  end
  // ==========================================================================
  // gray order 00 10 11 01, in-phase on the odd bit
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      port_out[2*i+1] = pos_reg[i][0] ^ pos_reg[i][1] ^ flip[2*i+1];
      port_out[2*i]   = pos_reg[i][1] ^ flip[2*i];
    end
  end
endmodule

/* sim/dqd_top_test.sv */
// self-checking bench for the dual quadrature decoder
`timescale 1ns/1ps
module dqd_top_test;
  localparam logic [9:0] ADRS [5] = '{10'h240, 10'h244, 10'h250, 10'h258, 10'h248};
  logic        clock;
  logic        rst;
  logic [9:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        prescale_tick;
  logic [7:0]  port_in;
  logic        irq;
  logic [1:0]  irq_priority;
  logic        step;
  logic        dn;
  logic [1:0]  pair;
  logic [7:0]  flip;
  logic [7:0]  rd;
  logic [7:0]  rd_q;
  logic        wait_q;
  logic [7:0]  wv;
  logic [7:0]  up;
  logic [1:0]  cp;
  logic [9:0]  ca;
  int          error_cnt;
  int          n_checks;
  int          seed;
  int          n;
  int          ch;
  int          s;
  int          p;

  dqd_top DUT (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .prescale_tick(prescale_tick), .port_in(port_in),
    .irq(irq), .irq_priority(irq_priority));
  dqd_encoder enc (.clock(clock), .rst(rst), .step(step), .dn(dn), .pair(pair),
    .flip(flip), .port_out(port_in));

  // ==========================================================================
  // clock and prescale tick every second cycle
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) prescale_tick <= ~prescale_tick;

  // bus answer settled mid-cycle, as it stands at the next rising edge
  always @(negedge clock) begin
    wait_q <= waitrequest;
    rd_q   <= readdata[7:0];
  end

  // ==========================================================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd,
                     input logic [3:0] be);
    int k;
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, wd};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wait_q !== 1'b0 && k < 20);
    if (k >= 20) begin
      error_cnt++;
    end
    rd = rd_q;
    read <= 1'b0;
    write <= 1'b0;
    @(negedge clock);
  endtask

  task automatic mv(input logic [1:0] pr, input logic d, input int k);
    repeat (k) begin
      @(posedge clock);
      pair <= pr;
      dn <= d;
      step <= 1'b1;
      @(posedge clock);
      step <= 1'b0;
      repeat (20) @(posedge clock);
    end
  endtask

  function automatic logic [7:0] ctl(input int c, input int sl, input logic [1:0] pr);
    return c ? {1'b1, sl[0], 4'h0, pr} : {4'h0, 1'b1, sl[0], pr};
  endfunction

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    conclude();
  end

  // ==========================================================================
  // main sequence
  initial begin
    seed = 32'h68ac;
    rst = 1'b1;
    {address, read, write, writedata, byteenable} = '0;
    {prescale_tick, step, dn, pair, flip} = '0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    foreach (ADRS[i]) begin
      bus(1'b0, ADRS[i], 8'h00, 4'h1);
      chk(rd, 8'h00);
    end
    for (p = 0; p < 4; p++) begin
      wv = 8'($random(seed));
      wv[1:0] = 2'(p);
      bus(1'b1, 10'h244, wv, 4'h1);
      bus(1'b0, 10'h244, 8'h00, 4'h1);
      chk(rd, wv & 8'hcf);
      chk({6'h0, irq_priority}, 8'(p));
    end
    bus(1'b1, 10'h244, 8'h00, 4'h0);
    bus(1'b0, 10'h244, 8'h00, 4'h1);
    chk(rd, wv & 8'hcf);
    for (ch = 0; ch < 2; ch++) begin
      for (s = 0; s < 2; s++) begin
        cp = {s[0], ch[0]};
        ca = ch ? 10'h258 : 10'h250;
        up = 8'h08 << (4 * ch);
        wv = ctl(ch, s, 2'(ch + s + 1));
        bus(1'b1, 10'h244, wv, 4'h1);
        n = 1 + ($random(seed) & 3);
        mv(cp, 1'b0, n);
        bus(1'b0, ca, 8'h00, 4'h1);
        chk(rd, 8'(n));
        mv(cp ^ 2'h2, 1'b0, 2);
        bus(1'b0, ca, 8'h00, 4'h1);
        chk(rd, 8'(n));
        mv(cp, 1'b1, n + 1);
        bus(1'b0, ca, 8'h00, 4'h1);
        chk(rd, 8'hff);
        chk({7'h0, irq}, 8'h01);
        bus(1'b0, 10'h240, 8'h00, 4'h1);
        chk(rd, up >> 1);
        bus(1'b0, 10'h240, 8'h00, 4'h1);
        chk(rd, 8'h00);
        chk({7'h0, irq}, 8'h00);
        mv(cp, 1'b0, 1);
        bus(1'b0, 10'h240, 8'h00, 4'h1);
        chk(rd, up);
        mv(cp, 1'b0, 2);
        bus(1'b1, 10'h240, 8'h00, 4'h1);
        bus(1'b0, ca, 8'h00, 4'h1);
        chk(rd, 8'h02);
        bus(1'b1, 10'h240, up >> 3, 4'h1);
        bus(1'b0, ca, 8'h00, 4'h1);
        chk(rd, 8'h00);
        bus(1'b0, 10'h240, 8'h00, 4'h1);
        chk(rd, 8'h00);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, 10'h244, wv & ~up, 4'h1);
        mv(cp, 1'b0, 2);
        bus(1'b1, 10'h244, wv, 4'h1);
        repeat (20) @(posedge clock);
        bus(1'b0, ca, 8'h00, 4'h1);
        chk(rd, 8'h00);
        @(posedge clock);
        flip <= 8'h02 << (2 * cp);
        repeat (2) @(posedge clock);
        flip <= 8'h00;
        repeat (20) @(posedge clock);
        bus(1'b0, ca, 8'h00, 4'h1);
        chk(rd, 8'h00);
      end
    end
    conclude();
  end
endmodule
